/* File: ptt_tester.sv */
// packet generator and monitor for the segmented local bus
`timescale 1ns/1ps
module ptt_tester
   import ptt_pkg::*;
#(
   parameter int NUM_PKTS = PKT_CNT_DEF,
   parameter int NSEG = NSEG_DEF,
   parameter ptt_rate_type LINE_RATE = RATE_12G5,
   parameter bit INBAND_FC_EN = 1'b1,
   parameter bit OOB_FC_EN = 1'b1
) (
   input wire logic clk, // system clock
   input wire logic srst, // sync reset, high
   input wire logic gtLocked, // transceiver lock
   input wire logic rxAligned, // receive alignment
   input wire logic burstMode, // 1 burst, 0 packet mode
   input wire logic restartIn, // relaunch request
   input wire logic errInjEn, // request error injection
   output ptt_seg_type [NSEG-1:0] txBeat, // transmit segments
   output logic txValid, // transmit beat valid
   input wire logic txReady, // core takes beat
   input wire logic txOverflow, // core fifo overflow
   input wire logic txUnderflow, // core fifo underflow
   input wire ptt_seg_type [NSEG-1:0] rxBeat, // receive segments
   input wire logic rxValid, // receive beat valid
   input wire logic ibFcStatErr, // in-band fc monitor error
   input wire logic oobFcStatErr, // out-of-band fc monitor error
   input wire logic errInjStat, // core error-injection status
   output logic inbandFlowCtlXoff, // in-band fc helper control
   output logic outOfBandFlowCtlXoff, // out-of-band fc helper control
   output logic errInjReq, // error injection pulse
   output logic txDoneLed, // all packets sent
   output logic txBusyLed, // generator busy
   output logic txFailLed, // fifo over/underflow seen
   output logic rxDoneLed, // all packets received, or receive gap timer expired
   output logic rxBusyLed, // monitor busy
   output logic rxErrLed, // data or count error
   output logic rxFcErrLed, // fc monitor error seen
   output logic rxErrInjLed, // error injection seen
   output logic sharedClk, // one clock for core and bus
   output logic [9:0] coreClkMhz, // core clock rate
   output logic [9:0] lbusClkMhz // bus clock rate
);
   initial begin
      if (NUM_PKTS < PKT_CNT_MIN || NUM_PKTS > PKT_CNT_MAX || (NUM_PKTS % 2) != 0) begin
         $error("packet count must be even and in range");
      end
      if (NSEG < 1 || NSEG > 16) begin
         $error("segment count out of range");
      end
   end

   localparam int BW = NSEG * $bits(ptt_seg_type);
   localparam logic [IDX_W:0] PKT_TOTAL = (IDX_W+1)'(NUM_PKTS);
   localparam logic [IDX_W:0] SEG_STEP = (IDX_W+1)'(NSEG);
   localparam logic [15:0] GAP_LIMIT = 16'(RX_GAP_CYC);

   typedef enum logic [1:0] {G_IDLE, G_WAIT, G_SEND, G_DONE} ptt_gen_state_type;
   typedef enum logic [1:0] {M_IDLE, M_WAIT, M_RECV, M_DONE} ptt_mon_state_type;

   ptt_gen_state_type genState_q, genState_d;
   ptt_mon_state_type monState_q, monState_d;
   logic [IDX_W:0] pktBase_q;
   logic [IDX_W:0] rxCnt_q;
   logic [15:0] gap_q;
   logic failSticky_q, rxErr_q, fcErr_q, errInjSeen_q, errInjReq_q;
   ptt_seg_type [NSEG-1:0] genBeat;
   logic bufInReady;
   logic [NSEG-1:0] segBad;
   logic [IDX_W:0] rxEnaCnt;

   wire linkUp = gtLocked && rxAligned;
   wire genValid = (genState_q == G_SEND) && linkUp;
   wire genTake = genValid && bufInReady;
   wire [IDX_W:0] pktNext = pktBase_q + SEG_STEP;
   wire rxTake = rxValid && (monState_q == M_RECV) && linkUp;
   wire [IDX_W:0] rxCntNext = rxCnt_q + rxEnaCnt;
   wire bothIdle = (genState_q == G_DONE) && (monState_q == M_DONE);
   wire restartGo = restartIn && bothIdle;
   wire rxMismatch = rxTake && ((|segBad) || (rxCntNext > PKT_TOTAL));
   wire gapExpired = (monState_q == M_RECV) && (gap_q >= GAP_LIMIT);

   // segment builder, one packet per segment
   for (genvar s = 0; s < NSEG; s++) begin : g_seg
      wire [IDX_W:0] idx = pktBase_q + (IDX_W+1)'(s);
      wire [IDX_W:0] rIdx = rxCnt_q + (IDX_W+1)'(s);
      assign genBeat[s].ena = (idx < PKT_TOTAL);
      assign genBeat[s].packetStartMarker = genBeat[s].ena;
      assign genBeat[s].packetEndMarker = genBeat[s].ena;
      assign genBeat[s].chan = chanFor(idx[IDX_W-1:0], burstMode);
      assign genBeat[s].data = swapBits(dataFor(idx[IDX_W-1:0]));
      assign segBad[s] = rxBeat[s].ena && (!rxBeat[s].packetStartMarker || !rxBeat[s].packetEndMarker
                         || rxBeat[s].chan != chanFor(rIdx[IDX_W-1:0], burstMode)
                         || swapBits(rxBeat[s].data) != dataFor(rIdx[IDX_W-1:0]));
   end

   // count of packets in a received beat
   always_comb begin
      rxEnaCnt = '0;
      for (int s = 0; s < NSEG; s++) begin
         rxEnaCnt = rxEnaCnt + (IDX_W+1)'(rxBeat[s].ena);
      end
   end

   // transmit path through the two-entry buffer
   ptt_two_entry_buffer #(
      .W(BW),
      .DEPTH(2)
   ) u_txBuf (
      .clk(clk),
      .srst(srst),
      .inData(genBeat),
      .inValid(genValid),
      .inReady(bufInReady),
      .outData(txBeat),
      .outValid(txValid),
      .outReady(txReady)
   );

   always_comb begin
      genState_d = genState_q;
      unique case (genState_q)
         G_IDLE: genState_d = G_WAIT;
         G_WAIT: genState_d = linkUp ? G_SEND : G_WAIT;
         G_SEND: genState_d = (genTake && pktNext >= PKT_TOTAL) ? G_DONE : G_SEND;
         G_DONE: genState_d = restartGo ? G_WAIT : G_DONE;
      endcase
   end

   always_comb begin
      monState_d = monState_q;
      unique case (monState_q)
         M_IDLE: monState_d = M_WAIT;
         M_WAIT: monState_d = linkUp ? M_RECV : M_WAIT;
         M_RECV: monState_d = ((rxTake && rxCntNext >= PKT_TOTAL) || gapExpired) ? M_DONE : M_RECV;
         M_DONE: monState_d = restartGo ? M_WAIT : M_DONE;
      endcase
   end

   // state registers
   always_ff @(posedge clk) begin
      if (srst) begin
         genState_q <= G_IDLE;
         monState_q <= M_IDLE;
      end else begin
         genState_q <= genState_d;
         monState_q <= monState_d;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || restartGo) begin
         pktBase_q <= PKT_IDX_RST;
         rxCnt_q <= PKT_IDX_RST;
      end else begin
         pktBase_q <= genTake ? pktNext : pktBase_q;
         rxCnt_q <= rxTake ? rxCntNext : rxCnt_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || monState_q != M_RECV || rxTake) begin
         gap_q <= GAP_RST;
      end else if (linkUp && !gapExpired) begin
         gap_q <= gap_q + 16'h0001;
      end
   end

   // sticky flags, set wins over restart
   always_ff @(posedge clk) begin
      if (srst) begin
         failSticky_q <= 1'b0;
         rxErr_q <= 1'b0;
         fcErr_q <= 1'b0;
         errInjSeen_q <= 1'b0;
      end else begin
         failSticky_q <= txOverflow || txUnderflow || (failSticky_q && !restartGo);
         rxErr_q <= rxMismatch || gapExpired || (rxErr_q && !restartGo);
         fcErr_q <= ibFcStatErr || oobFcStatErr || (fcErr_q && !restartGo);
         errInjSeen_q <= errInjStat || (errInjSeen_q && !restartGo);
      end
   end

   // error injection pulse on the first beat of a run
   always_ff @(posedge clk) begin
      if (srst) begin
         errInjReq_q <= 1'b0;
      end else begin
         errInjReq_q <= errInjEn && genTake && (pktBase_q == PKT_IDX_RST);
      end
   end

   // in-band flow-control helper, toggles per sent beat
   if (INBAND_FC_EN) begin : g_inband_flow_ctl
      logic xoff_q;
      always_ff @(posedge clk) begin
         if (srst) begin
            xoff_q <= 1'b0;
         end else if (genTake) begin
            xoff_q <= ~xoff_q;
         end
      end
      assign inbandFlowCtlXoff = xoff_q;
   end else begin : g_no_inband_flow_ctl
      assign inbandFlowCtlXoff = 1'b0;
   end

   // out-of-band flow-control helper, asserted while the generator is stalled by a full buffer
   if (OOB_FC_EN) begin : g_out_of_band_flow_ctl
      logic xoff_q;
      always_ff @(posedge clk) begin
         if (srst) begin
            xoff_q <= 1'b0;
         end else begin
            xoff_q <= genValid && !bufInReady;
         end
      end
      assign outOfBandFlowCtlXoff = xoff_q;
   end else begin : g_no_out_of_band_flow_ctl
      assign outOfBandFlowCtlXoff = 1'b0;
   end

   // status outputs
   assign errInjReq = errInjReq_q;
   assign txDoneLed = (genState_q == G_DONE);
   assign txBusyLed = (genState_q != G_DONE);
   assign txFailLed = failSticky_q;
   assign rxDoneLed = (monState_q == M_DONE);
   assign rxBusyLed = (monState_q != M_DONE);
   assign rxErrLed = rxErr_q;
   assign rxFcErrLed = fcErr_q;
   assign rxErrInjLed = errInjSeen_q;

   assign sharedClk = (LINE_RATE == RATE_12G5);
   assign coreClkMhz = (LINE_RATE == RATE_12G5) ? CORE_CLK_MHZ_LOW : CORE_CLK_MHZ_HIGH;
   assign lbusClkMhz = LBUS_CLK_MHZ;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_genDoneCount;
      $rose(txDoneLed) |-> pktBase_q >= PKT_TOTAL && pktBase_q < PKT_TOTAL + SEG_STEP;
   endproperty
   a_genDoneCount: assert property (p_genDoneCount) else $error("generator stopped at wrong count");

   property p_monDoneCount;
      $rose(rxDoneLed) && !rxErrLed |-> rxCnt_q == PKT_TOTAL;
   endproperty
   a_monDoneCount: assert property (p_monDoneCount) else $error("monitor done at wrong count");

   property p_sendNeedsLink;
      $rose(txValid) |-> $past(gtLocked && rxAligned) && $past(genState_q == G_SEND);
   endproperty
   a_sendNeedsLink: assert property (p_sendNeedsLink) else $error("traffic sent without link");

   property p_recvNeedsLink;
      !(gtLocked && rxAligned) |=> rxCnt_q == $past(rxCnt_q) || rxCnt_q == PKT_IDX_RST;
   endproperty
   a_recvNeedsLink: assert property (p_recvNeedsLink) else $error("traffic taken without link");

   property p_txHold;
      txValid && !txReady |=> txValid && $stable(txBeat);
   endproperty
   a_txHold: assert property (p_txHold) else $error("transmit beat changed under stall");

   property p_markers;
      genValid |-> genBeat[0].packetStartMarker && genBeat[0].packetEndMarker;
   endproperty
   a_markers: assert property (p_markers) else $error("segment lacks markers");

   property p_packetChan;
      genValid && !burstMode |-> genBeat[0].chan == pktBase_q[CHAN_W-1:0];
   endproperty
   a_packetChan: assert property (p_packetChan) else $error("packet mode channel wrong");

   property p_burstChan;
      genValid && burstMode |-> genBeat[0].chan == (pktBase_q[0] ? BURST_CHAN_B : BURST_CHAN_A);
   endproperty
   a_burstChan: assert property (p_burstChan) else $error("burst mode channel wrong");

   property p_swap;
      genValid |-> swapBits(genBeat[0].data) == dataFor(pktBase_q[IDX_W-1:0]);
   endproperty
   a_swap: assert property (p_swap) else $error("data not bit swapped");

   property p_restartGuard;
      restartIn && txDoneLed && !rxDoneLed |=> txDoneLed;
   endproperty
   a_restartGuard: assert property (p_restartGuard) else $error("restart taken while busy");

   property p_fail;
      txOverflow || txUnderflow |=> txFailLed ##1 (txFailLed || $past(restartGo));
   endproperty
   a_fail: assert property (p_fail) else $error("fifo failure not flagged");

   property p_mismatch;
      rxMismatch |=> rxErrLed;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

   property p_fcStatus;
      ibFcStatErr || oobFcStatErr |=> rxFcErrLed;
   endproperty
   a_fcStatus: assert property (p_fcStatus) else $error("fc monitor error lost");

   c_genDone: cover property ($rose(txDoneLed));
   c_monDone: cover property ($rose(rxDoneLed) && !rxErrLed);
   c_restart: cover property (restartGo ##1 genState_q == G_WAIT);
   c_stall: cover property (txValid && !txReady ##1 txValid && txReady);
endmodule

/* File: ptt_pkg.sv */
// constants, types and helper functions of the packet traffic tester
package ptt_pkg;
   localparam int SEG_DATA_W = 32;
   localparam int CHAN_W = 8;
   localparam int IDX_W = 16;
   localparam int PKT_CNT_MIN = 2;
   localparam int PKT_CNT_MAX = 65534;
   localparam int PKT_CNT_DEF = 20;
   localparam int NSEG_DEF = 4;
   localparam logic [CHAN_W-1:0] BURST_CHAN_A = 8'h05;
   localparam logic [CHAN_W-1:0] BURST_CHAN_B = 8'h0a;
   localparam logic [IDX_W:0] PKT_IDX_RST = 17'h00000;
   // clock and timing
   localparam int CLK_MHZ = 40;
   localparam int RX_GAP_NS = 10000;
   localparam int RX_GAP_CYC = (RX_GAP_NS * CLK_MHZ) / 1000;
   localparam logic [15:0] GAP_RST = 16'h0000;
   // clock plan per line rate
   localparam logic [9:0] LBUS_CLK_MHZ = 10'd300;
   localparam logic [9:0] CORE_CLK_MHZ_LOW = 10'd300;
   localparam logic [9:0] CORE_CLK_MHZ_HIGH = 10'd412;

   typedef enum logic {RATE_12G5, RATE_25G78} ptt_rate_type;

   typedef struct packed {
      logic ena;
      logic packetStartMarker;
      logic packetEndMarker;
      logic [CHAN_W-1:0] chan;
      logic [SEG_DATA_W-1:0] data;
   } ptt_seg_type;

   // channel of packet number idx
   function automatic logic [CHAN_W-1:0] chanFor(input logic [IDX_W-1:0] idx, input logic burst);
      chanFor = burst ? (idx[0] ? BURST_CHAN_B : BURST_CHAN_A) : idx[CHAN_W-1:0];
   endfunction

   // payload of packet number idx
   function automatic logic [SEG_DATA_W-1:0] dataFor(input logic [IDX_W-1:0] idx);
      dataFor = {idx, ~idx};
   endfunction

   // bit reversal of the data path
   function automatic logic [SEG_DATA_W-1:0] swapBits(input logic [SEG_DATA_W-1:0] d);
      for (int i = 0; i < SEG_DATA_W; i++) begin
         swapBits[i] = d[SEG_DATA_W-1-i];
      end
   endfunction
endpackage

/* File: ptt_two_entry_buffer.sv */
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module ptt_two_entry_buffer #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk, // system clock
   input wire logic srst, // sync reset, high
   input wire logic [W-1:0] inData, // word to store
   input wire logic inValid, // word offered
   output logic inReady, // room for a word
   output logic [W-1:0] outData, // oldest word
   output logic outValid, // oldest word present
   input wire logic outReady // drain accepts
);
   localparam int PW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("buffer depth must be a power of two, at least 2");
      end
   end

   logic [W-1:0] mem_q [DEPTH];
   logic [PW-1:0] wrPtr_q;
   logic [PW-1:0] rdPtr_q;
   logic [PW:0] fill_q;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;

   // honest full and empty
   assign inReady = (fill_q != (PW+1)'(DEPTH));
   assign outValid = (fill_q != '0);
   assign outData = mem_q[rdPtr_q];

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         fill_q <= '0;
      end else begin
         wrPtr_q <= push ? wrPtr_q + 1'b1 : wrPtr_q;
         rdPtr_q <= pop ? rdPtr_q + 1'b1 : rdPtr_q;
         fill_q <= fill_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end
endmodule

/* File: ptt_core_model.sv */
// loopback model of the protocol core on the segmented local bus
`timescale 1ns/1ps
module ptt_core_model
   import ptt_pkg::*;
#(
   parameter int NSEG = NSEG_DEF
) (
   input wire logic clk, // system clock
   input wire logic srst, // sync reset, high
   input wire ptt_seg_type [NSEG-1:0] txBeat, // beat from tester
   input wire logic txValid, // beat offered
   output logic txReady, // beat taken
   input wire logic allowTake, // bench permits taking
   input wire logic [1:0] fault, // 0 clean, 1 corrupt, 2 drop
   output ptt_seg_type [NSEG-1:0] rxBeat, // looped-back beat
   output logic rxValid // looped-back beat valid
);
   ptt_seg_type [NSEG-1:0] rxBeat_q;
   logic rxValid_q;
   logic take;
   assign txReady = allowTake;
   assign take = txValid && allowTake;
   assign rxBeat = rxBeat_q;
   assign rxValid = rxValid_q;
   // taken beat comes back next cycle, junk between beats
   always_ff @(posedge clk) begin
      if (srst) begin
         rxValid_q <= 1'b0;
         rxBeat_q <= '0;
      end else if (take && fault != 2'h2) begin
         rxValid_q <= 1'b1;
         rxBeat_q <= txBeat;
         if (fault == 2'h1) begin
            rxBeat_q[0].data[0] <= ~txBeat[0].data[0];
         end
      end else begin
         rxValid_q <= 1'b0;
         rxBeat_q <= ~rxBeat_q;
      end
   end
endmodule

/* File: packet_traffic_tester_bench.sv */
// self-checking bench of the packet traffic tester
`timescale 1ns/1ps
module packet_traffic_tester_bench;
   import ptt_pkg::*;
   localparam int NPK = 10;
   logic clk = 1'b0, srst = 1'b1, gtLocked = 1'b0, rxAligned = 1'b0, burstMode = 1'b0;
   logic restartIn = 1'b0, errInjEn = 1'b0, txOverflow = 1'b0, txUnderflow = 1'b0;
   logic ibFcStatErr = 1'b0, oobFcStatErr = 1'b0, errInjStat = 1'b0, allowTake = 1'b0, randReady = 1'b0;
   logic [1:0] fault = 2'h0;
   ptt_seg_type [NSEG_DEF-1:0] txBeat, rxBeat, held;
   logic txValid, txReady, rxValid, inbandFlowCtlXoff, outOfBandFlowCtlXoff, errInjReq, sharedClk;
   logic txDoneLed, txBusyLed, txFailLed, rxDoneLed, rxBusyLed, rxErrLed, rxFcErrLed, rxErrInjLed;
   logic [9:0] coreClkMhz, lbusClkMhz;
   int fails = 0, samples_checked = 0, beatIdx = 0, injPulses = 0, seedDummy;
   logic oobSeen = 1'b0;
   logic sharedClkAlt, ibXoffAlt, oobXoffAlt;
   logic [9:0] coreClkMhzAlt, lbusClkMhzAlt;

   ptt_tester #(.NUM_PKTS(NPK)) i_ptt_tester (.clk(clk), .srst(srst), .gtLocked(gtLocked),
      .rxAligned(rxAligned), .burstMode(burstMode), .restartIn(restartIn), .errInjEn(errInjEn),
      .txBeat(txBeat), .txValid(txValid), .txReady(txReady), .txOverflow(txOverflow),
      .txUnderflow(txUnderflow), .rxBeat(rxBeat), .rxValid(rxValid), .ibFcStatErr(ibFcStatErr),
      .oobFcStatErr(oobFcStatErr), .errInjStat(errInjStat), .inbandFlowCtlXoff(inbandFlowCtlXoff),
      .outOfBandFlowCtlXoff(outOfBandFlowCtlXoff), .errInjReq(errInjReq), .txDoneLed(txDoneLed),
      .txBusyLed(txBusyLed), .txFailLed(txFailLed), .rxDoneLed(rxDoneLed), .rxBusyLed(rxBusyLed),
      .rxErrLed(rxErrLed), .rxFcErrLed(rxFcErrLed), .rxErrInjLed(rxErrInjLed), .sharedClk(sharedClk),
      .coreClkMhz(coreClkMhz), .lbusClkMhz(lbusClkMhz));
   // second build: higher line rate, no flow-control helpers
   ptt_tester #(.NUM_PKTS(NPK), .LINE_RATE(RATE_25G78), .INBAND_FC_EN(1'b0), .OOB_FC_EN(1'b0)) i_ptt_tester_alt (
      .clk(clk), .srst(srst), .gtLocked(gtLocked), .rxAligned(rxAligned), .burstMode(burstMode),
      .restartIn(restartIn), .errInjEn(errInjEn), .txBeat(), .txValid(), .txReady(txReady),
      .txOverflow(txOverflow), .txUnderflow(txUnderflow), .rxBeat(rxBeat), .rxValid(rxValid),
      .ibFcStatErr(ibFcStatErr), .oobFcStatErr(oobFcStatErr), .errInjStat(errInjStat),
      .inbandFlowCtlXoff(ibXoffAlt), .outOfBandFlowCtlXoff(oobXoffAlt), .errInjReq(), .txDoneLed(),
      .txBusyLed(), .txFailLed(), .rxDoneLed(), .rxBusyLed(), .rxErrLed(), .rxFcErrLed(), .rxErrInjLed(),
      .sharedClk(sharedClkAlt), .coreClkMhz(coreClkMhzAlt), .lbusClkMhz(lbusClkMhzAlt));
   ptt_core_model i_ptt_core_model (.clk(clk), .srst(srst), .txBeat(txBeat), .txValid(txValid),
      .txReady(txReady), .allowTake(allowTake), .fault(fault), .rxBeat(rxBeat), .rxValid(rxValid));

   // compare and count
   task automatic check(input logic [171:0] seen, input logic [171:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // expected segment of packet idx, data bit-reversed on the wire
   function automatic ptt_seg_type segExp(input int idx);
      ptt_seg_type e;
      logic [31:0] raw;
      raw = {idx[15:0], ~idx[15:0]};
      e.ena = 1'b1;
      e.packetStartMarker = 1'b1;
      e.packetEndMarker = 1'b1;
      e.chan = burstMode ? (idx[0] ? BURST_CHAN_B : BURST_CHAN_A) : idx[7:0];
      for (int i = 0; i < 32; i++) e.data[i] = raw[31 - i];
      return e;
   endfunction

   initial begin
      forever #12.5 clk = ~clk;
   end

   // random readiness of the far side
   always @(posedge clk) begin
      if (randReady) allowTake <= ($urandom_range(3) != 0);
   end

   // every taken beat against the expected packet sequence
   always @(posedge clk) begin
      if (srst === 1'b0 && txValid === 1'b1 && txReady === 1'b1) begin
         for (int s = 0; s < NSEG_DEF; s++) begin
            if (beatIdx * NSEG_DEF + s < NPK) check(172'(txBeat[s]), 172'(segExp(beatIdx * NSEG_DEF + s)), "seg");
            else check(172'(txBeat[s].ena), 172'h0, "unused segment enabled");
         end
         beatIdx++;
      end
      if (errInjReq === 1'b1) injPulses++;
      if (outOfBandFlowCtlXoff === 1'b1) oobSeen = 1'b1;
   end

   // wait for both halves done, then judge the run
   task automatic runAndCheck(input logic bad);
      int n = 0;
      while (!(txDoneLed === 1'b1 && rxDoneLed === 1'b1) && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(172'(n >= 3000), 172'h0, "run timed out");
      check(172'(beatIdx), 172'((NPK + NSEG_DEF - 1) / NSEG_DEF), "beat count");
      check(rxErrLed, bad, "receive error flag");
      $display("run finished, fault %0d burst %0d", fault, burstMode);
   endtask

   task automatic restart();
      @(posedge clk);
      beatIdx = 0;
      restartIn <= 1'b1;
      @(posedge clk);
      restartIn <= 1'b0;
      #1;
      check({txDoneLed, rxDoneLed, txFailLed, rxFcErrLed, rxErrInjLed, rxErrLed}, 6'h00, "restart");
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      final_report();
   end

   initial begin
      seedDummy = $urandom(89);
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      check({txValid, errInjReq, txDoneLed, rxDoneLed, txBusyLed, rxBusyLed, txFailLed, rxErrLed}, 8'h0c, "reset");
      check({sharedClk, coreClkMhz, lbusClkMhz}, {1'b1, 10'h12c, 10'h12c}, "clock plan");
      check({sharedClkAlt, coreClkMhzAlt, lbusClkMhzAlt}, {1'b0, 10'h19c, 10'h12c}, "fast clock plan");
      $display("reset test done");
      // lock without alignment must not start traffic
      errInjEn <= 1'b1;
      gtLocked <= 1'b1;
      repeat (40) begin
         @(posedge clk);
         #1;
         check(txValid, 1'b0, "sent before alignment");
      end
      rxAligned <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      held = txBeat;
      check(txValid, 1'b1, "no beat offered");
      repeat (4) @(posedge clk);
      #1;
      check(txBeat, held, "beat changed in stall");
      check({outOfBandFlowCtlXoff, oobXoffAlt}, 2'h2, "oob helper presence");
      $display("link gating test done");
      randReady = 1'b1;
      runAndCheck(1'b0);
      check(172'(injPulses), 172'h1, "injection pulses");
      check({inbandFlowCtlXoff, oobSeen}, 2'h3, "flow control helpers");
      check(ibXoffAlt, 1'b0, "in-band helper presence");
      // sticky status flags
      txOverflow <= 1'b1;
      ibFcStatErr <= 1'b1;
      errInjStat <= 1'b1;
      @(posedge clk);
      txOverflow <= 1'b0;
      ibFcStatErr <= 1'b0;
      errInjStat <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check({txFailLed, rxFcErrLed, rxErrInjLed}, 3'h7, "status flags");
      $display("packet mode test done");
      burstMode <= 1'b1;
      restart();
      repeat (5) @(posedge clk);
      restartIn <= 1'b1;
      @(posedge clk);
      restartIn <= 1'b0;
      runAndCheck(1'b0);
      txUnderflow <= 1'b1;
      oobFcStatErr <= 1'b1;
      @(posedge clk);
      txUnderflow <= 1'b0;
      oobFcStatErr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check({txFailLed, rxFcErrLed}, 2'h3, "underflow and oob flags");
      $display("burst mode test done");
      burstMode <= 1'b0;
      fault <= 2'h1;
      restart();
      runAndCheck(1'b1);
      $display("corrupt packet test done");
      fault <= 2'h2;
      restart();
      runAndCheck(1'b1);
      $display("missing packet test done");
      final_report();
   end
endmodule
